// File: common/csl_pkg.sv
// constants, states and functional notes for the charge supervision logic
// assumes a single 40 MHz clock; analog comparators arrive as synchronous levels
// Functional notes
// - The indicator is off in qualification, complete, sleep and disconnected states, and on while charging.
// - A safety timer fault, or an invalid cell temperature in qualification or charging, flashes the indicator at 1 Hz, half on and half off.
// - The flash period comes from the same time base as the safety timers and scales with it.
// - A high enable input lets the device run charge cycles.
// - A low enable input ends any charge and puts the device to sleep with the indicator off.
// - Lowering enable ends a charge at any phase and raising it again starts a new cycle.
// - The pass gate drive is forced off whenever the supply is below the lockout level.
// - Below the lockout level the device enters a low-power state and halts charging.
// - Constant-current fast charge always comes before constant voltage.
// - A cell still under the precharge threshold when the precondition timer expires ends the charge in fault.
// - Three safety timers run for 1.0, 1.5 and 3.0 hours at the reference time base.
// - The precondition timer runs only in precondition; fast and elapsed timers start on leaving precondition, fast clears in constant voltage.
// - After completion a new cycle starts when the cell drops under the recharge threshold and qualification holds.
package csl_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // time base tick at reference capacitance: 2 Hz, half of one flash period
  localparam int unsigned TICK_HZ = 2;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned PRECON_HOURS_X10 = 10;
  localparam int unsigned FAST_HOURS_X10 = 15;
  localparam int unsigned TERM_HOURS_X10 = 30;
  localparam int unsigned PRECON_TICKS = PRECON_HOURS_X10 * 360 * TICK_HZ;
  localparam int unsigned FAST_TICKS = FAST_HOURS_X10 * 360 * TICK_HZ;
  localparam int unsigned TERM_TICKS = TERM_HOURS_X10 * 360 * TICK_HZ;
  localparam int unsigned TMR_W = 16;

  typedef enum logic [3:0] {
    CSL_SLEEP = 4'b0000,
    CSL_QUAL = 4'b0001,
    CSL_PRECON = 4'b0010,
    CSL_FAST = 4'b0011,
    CSL_CV = 4'b0100,
    CSL_DONE = 4'b0101,
    CSL_TFAULT = 4'b0110,
    CSL_TEMPBAD = 4'b0111,
    CSL_NOBAT = 4'b1000,
    CSL_LOCKOUT = 4'b1001
  } csl_state_t;
endpackage

// File: src/csl_timer.sv
// one safety timer: counts time base ticks while running, flags expiry
// assumes tick_in is a one-cycle pulse; clear_in wins over counting
`timescale 1ns/100ps
module csl_timer #(
  parameter int unsigned LIMIT = 7200
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // control
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic tick_in,
  // status
  output logic expired_out
);
  logic [csl_pkg::TMR_W-1:0] count_reg;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in || clear_in)
    begin
      count_reg <= '0;
      expired_out <= 1'b0;
    end
    else if (run_in && tick_in && !expired_out)
    begin
      count_reg <= count_reg + 1'b1;
      if (count_reg == csl_pkg::TMR_W'(LIMIT - 1))
        expired_out <= 1'b1;
    end
  end
endmodule // csl_timer

// File: src/csl_top.sv
// charge supervision: cycle sequencing, safety timers, status indicator, gate drive enable
// assumes comparator inputs are clean synchronous levels; tick_in from the timing capacitor
`timescale 1ns/100ps
module csl_top #(
  // internal divider period, shortened in simulation
  parameter int unsigned TICK_DIV = csl_pkg::TICK_DIV
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // time base from the timing capacitor oscillator, one pulse per half flash period
  input wire logic cap_tick_in,
  input wire logic use_cap_tick_in,
  // enable and supply
  input wire logic charge_enable_in,
  input wire logic supply_ok_in,
  // cell comparators
  input wire logic battery_present_in,
  input wire logic cell_temp_ok_in,
  input wire logic above_precharge_threshold_in,
  input wire logic at_target_cell_voltage_in,
  input wire logic below_recharge_threshold_in,
  input wire logic current_below_term_in,
  // outputs
  output logic pass_gate_drive_out,
  output logic precondition_current_out,
  output logic low_power_out,
  output logic charge_state_indicator_o_out,
  output logic charge_state_indicator_oe_n_out,
  output logic [3:0] state_out
);
  csl_pkg::csl_state_t state_reg, state_next;
  logic [25:0] div_reg;
  logic div_tick;
  logic tick;
  logic flash_reg;
  logic pre_exp, fast_exp, term_exp;
  logic ind_on;
  logic charging;

  // internal divider only as a stand-in for the capacitor oscillator
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || div_tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign div_tick = (div_reg == 26'(TICK_DIV - 1));
  assign tick = use_cap_tick_in ? cap_tick_in : div_tick;

  // flash toggles on every time base tick: equal halves of one period
  // limitation: the tick runs free, so the first off half after a fault may be short
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      flash_reg <= 1'b0;
    else if (state_reg != csl_pkg::CSL_TFAULT && state_reg != csl_pkg::CSL_TEMPBAD)
      flash_reg <= 1'b0;
    else if (tick)
      flash_reg <= ~flash_reg;
  end

  // safety timers
  csl_timer #(.LIMIT(csl_pkg::PRECON_TICKS)) u_pre (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clear_in(state_reg != csl_pkg::CSL_PRECON),
    .run_in(1'b1),
    .tick_in(tick),
    .expired_out(pre_exp)
  );
  // fast timer clears on entering constant voltage, since its phase is left
  csl_timer #(.LIMIT(csl_pkg::FAST_TICKS)) u_fast (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clear_in(state_reg != csl_pkg::CSL_FAST),
    .run_in(1'b1),
    .tick_in(tick),
    .expired_out(fast_exp)
  );
  // elapsed timer spans fast charge and constant voltage; in the latter it ends the cycle
  csl_timer #(.LIMIT(csl_pkg::TERM_TICKS)) u_term (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clear_in(state_reg != csl_pkg::CSL_FAST && state_reg != csl_pkg::CSL_CV),
    .run_in(1'b1),
    .tick_in(tick),
    .expired_out(term_exp)
  );

  // sequencing; lockout and enable override every phase
  // battery removal comes next, then the phase logic
  always_comb
  begin
    state_next = state_reg;
    if (!supply_ok_in)
      state_next = csl_pkg::CSL_LOCKOUT;
    else if (!charge_enable_in)
      state_next = csl_pkg::CSL_SLEEP;
    else if (!battery_present_in)
      state_next = csl_pkg::CSL_NOBAT;
    else
    begin
      case (state_reg)
        csl_pkg::CSL_SLEEP, csl_pkg::CSL_LOCKOUT, csl_pkg::CSL_NOBAT:
          state_next = csl_pkg::CSL_QUAL;
        // a cell outside its temperature window never advances; the pin flashes instead
        csl_pkg::CSL_QUAL:
          if (!cell_temp_ok_in)
            state_next = csl_pkg::CSL_TEMPBAD;
          else
            state_next = csl_pkg::CSL_PRECON;
        csl_pkg::CSL_PRECON:
          if (!cell_temp_ok_in)
            state_next = csl_pkg::CSL_TEMPBAD;
          else if (above_precharge_threshold_in)
            state_next = csl_pkg::CSL_FAST;
          else if (pre_exp)
            state_next = csl_pkg::CSL_TFAULT;
        csl_pkg::CSL_FAST:
          if (!cell_temp_ok_in)
            state_next = csl_pkg::CSL_TEMPBAD;
          else if (at_target_cell_voltage_in)
            state_next = csl_pkg::CSL_CV;
          else if (fast_exp || term_exp)
            state_next = csl_pkg::CSL_TFAULT;
        csl_pkg::CSL_CV:
          if (!cell_temp_ok_in)
            state_next = csl_pkg::CSL_TEMPBAD;
          else if (current_below_term_in || term_exp)
            state_next = csl_pkg::CSL_DONE;
        // a full cell waits here; only a drop under the recharge threshold with the cell temperature ok restarts
        csl_pkg::CSL_DONE:
          if (below_recharge_threshold_in && cell_temp_ok_in)
            state_next = csl_pkg::CSL_QUAL;
        csl_pkg::CSL_TEMPBAD:
          if (cell_temp_ok_in)
            state_next = csl_pkg::CSL_QUAL;
        csl_pkg::CSL_TFAULT:
          state_next = csl_pkg::CSL_TFAULT; // left only by lowering enable, supply lockout or battery removal
        default:
          state_next = csl_pkg::CSL_SLEEP;
      endcase
    end
  end

  // enable and supply are levels; no edge detect, so a held low keeps the block asleep
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      state_reg <= csl_pkg::CSL_SLEEP;
    else
      state_reg <= state_next;
  end

  // decoded from state_next so every output flop lines up with state_out
  assign charging = (state_next == csl_pkg::CSL_PRECON) || (state_next == csl_pkg::CSL_FAST)
                    || (state_next == csl_pkg::CSL_CV);

  // indicator request, before the open-drain inversion
  always_comb
  begin
    case (state_next)
      csl_pkg::CSL_PRECON, csl_pkg::CSL_FAST, csl_pkg::CSL_CV:
        ind_on = 1'b1;
      csl_pkg::CSL_TFAULT, csl_pkg::CSL_TEMPBAD:
        ind_on = flash_reg;
      default:
        ind_on = 1'b0;
    endcase
  end

  // registered outputs, one flop each so no pin sees a glitch of state_next
  // gate drive: supply is checked again so a stale phase can never drive the gate
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      pass_gate_drive_out <= 1'b0;
    else
      pass_gate_drive_out <= charging && supply_ok_in;
  end

  // trickle current request, high only in precondition
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      precondition_current_out <= 1'b0;
    else
      precondition_current_out <= (state_next == csl_pkg::CSL_PRECON);
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      low_power_out <= 1'b1;
    else
      low_power_out <= (state_next == csl_pkg::CSL_LOCKOUT)
                       || (state_next == csl_pkg::CSL_SLEEP);
  end

  // open-drain pin: data stays low, only the enable moves
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      charge_state_indicator_o_out <= 1'b0;
      charge_state_indicator_oe_n_out <= 1'b1;
    end
    else
    begin
      charge_state_indicator_o_out <= 1'b0;
      charge_state_indicator_oe_n_out <= ~ind_on;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      state_out <= 4'h0;
    else
      state_out <= state_next;
  end
endmodule // csl_top

// File: bench/csl_pullup_host.sv
// far side of the status pin: pull-up resistor into a host input
// expects the split open-drain controls of csl_top
`timescale 1ns/100ps
module csl_pullup_host (
  // open-drain controls
  input wire logic oe_n_in,
  input wire logic o_in,
  // resolved pin level
  output logic pin_out
);
  // a released pin is pulled high, never left at its last value
  assign pin_out = oe_n_in ? 1'b1 : o_in;
endmodule // csl_pullup_host

// File: bench/csl_props.sv
// port assertions for the charge supervision top
// bound into csl_top; one clock, sync reset
`timescale 1ns/100ps
module csl_props (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // watched ports
  input wire logic charge_enable_in,
  input wire logic supply_ok_in,
  input wire logic battery_present_in,
  input wire logic pass_gate_drive_out,
  input wire logic low_power_out,
  input wire logic charge_state_indicator_oe_n_out,
  input wire logic [3:0] state_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire oe_n = charge_state_indicator_oe_n_out;
  sequence s_enter_cv;
    state_out == 4'h4 && $past(state_out) != 4'h4;
  endsequence
  sequence s_idle_go;
    state_out == 4'h0 && charge_enable_in && supply_ok_in && battery_present_in;
  endsequence
  a_on_charging:
  assert property (state_out inside {4'h2, 4'h3, 4'h4} |-> !oe_n) else $error("status off");
  a_off_idle:
  assert property (state_out inside {4'h0, 4'h1, 4'h5, 4'h8, 4'h9} |-> oe_n) else $error("on");
  a_lockout_drive:
  assert property (!supply_ok_in |=> !pass_gate_drive_out && state_out == 4'h9) else $error("drv");
  a_lockout_power:
  assert property (!supply_ok_in |=> low_power_out) else $error("no low power");
  a_disable_sleep:
  assert property (supply_ok_in && !charge_enable_in |=> state_out == 4'h0 && oe_n) else $error("en");
  a_fast_before_cv:
  assert property (s_enter_cv |-> $past(state_out) == 4'h3) else $error("cv not after fast");
  a_fault_holds:
  assert property (state_out == 4'h6 && supply_ok_in && charge_enable_in && battery_present_in
    |=> state_out == 4'h6) else $error("fault left");
  a_enable_starts:
  assert property (s_idle_go |=> state_out == 4'h1) else $error("no start");
endmodule // csl_props
bind csl_top csl_props u_props (.mclk_in, .rst_in, .charge_enable_in, .supply_ok_in,
  .battery_present_in, .pass_gate_drive_out, .low_power_out, .charge_state_indicator_oe_n_out,
  .state_out);

// File: bench/testbench.sv
// self-checking bench for csl_top with a pull-up host on the status pin
// one 40 MHz clock; the cap tick is made here so the timers run fast
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst = 1, tk = 0, en = 0, sup = 1, bat = 1, tmp = 1;
  logic pre = 0, tgt = 0, rch = 0, trm = 0, drv, pcur, lowp, so, soe, pin;
  logic usec = 1, p0;
  logic [3:0] st;
  logic [5:0] exp_q[$];
  event seen_ev;
  int miscompares = 0, n_compared = 0;
  csl_top #(.TICK_DIV(10)) u_dut (.mclk_in(clk), .rst_in(rst), .cap_tick_in(tk),
    .use_cap_tick_in(usec), .charge_enable_in(en), .supply_ok_in(sup),
    .battery_present_in(bat), .cell_temp_ok_in(tmp), .above_precharge_threshold_in(pre),
    .at_target_cell_voltage_in(tgt), .below_recharge_threshold_in(rch),
    .current_below_term_in(trm), .pass_gate_drive_out(drv), .precondition_current_out(pcur),
    .low_power_out(lowp), .charge_state_indicator_o_out(so),
    .charge_state_indicator_oe_n_out(soe), .state_out(st));
  csl_pullup_host u_host (.oe_n_in(soe), .o_in(so), .pin_out(pin));
  initial forever #12.5 clk = ~clk;
  task automatic check(string nm, logic [3:0] seen, logic [3:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one cycle on, then note state and {pin, drive} once settled
  task automatic expect_st(csl_pkg::csl_state_t s, logic [1:0] pd);
    @(posedge clk);
    @(negedge clk);
    exp_q.push_back({s, pd});
    -> seen_ev;
  endtask
  task automatic ticks(int n, int gap);
    repeat (n)
    begin
      @(posedge clk) tk <= 1'b1;
      @(posedge clk) tk <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(seen_ev)
  begin : watch
    logic [5:0] e;
    logic lp;
    e = exp_q.pop_front();
    lp = (e[5:2] == csl_pkg::CSL_SLEEP) || (e[5:2] == csl_pkg::CSL_LOCKOUT);
    check("state", st, e[5:2]);
    check("pin", {3'h0, pin}, {3'h0, e[1]});
    check("drive", {3'h0, drv}, {3'h0, e[0]});
    check("precond", {3'h0, pcur}, {3'h0, (e[5:2] == csl_pkg::CSL_PRECON)});
    check("lowpower", {3'h0, lowp}, {3'h0, lp});
  end
  initial
  begin : watchdog
    repeat (40000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial
  begin : main
    int i;
    void'($urandom(58));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    expect_st(csl_pkg::CSL_SLEEP, 2'b10);
    @(posedge clk) en <= 1'b1;
    expect_st(csl_pkg::CSL_QUAL, 2'b10);
    expect_st(csl_pkg::CSL_PRECON, 2'b01);
    @(posedge clk) pre <= 1'b1;
    expect_st(csl_pkg::CSL_FAST, 2'b01);
    @(posedge clk) tgt <= 1'b1;
    expect_st(csl_pkg::CSL_CV, 2'b01);
    @(posedge clk) trm <= 1'b1;
    expect_st(csl_pkg::CSL_DONE, 2'b10);
    @(posedge clk) {tgt, trm, rch} <= 3'b001;
    expect_st(csl_pkg::CSL_QUAL, 2'b10);
    expect_st(csl_pkg::CSL_PRECON, 2'b01);
    expect_st(csl_pkg::CSL_FAST, 2'b01);
    @(posedge clk) en <= 1'b0;
    expect_st(csl_pkg::CSL_SLEEP, 2'b10);
    @(posedge clk) en <= 1'b1;
    expect_st(csl_pkg::CSL_QUAL, 2'b10);
    expect_st(csl_pkg::CSL_PRECON, 2'b01);
    @(posedge clk) tmp <= 1'b0;
    expect_st(csl_pkg::CSL_TEMPBAD, 2'b10);
    @(posedge clk) tmp <= 1'b1;
    expect_st(csl_pkg::CSL_QUAL, 2'b10);
    @(posedge clk) sup <= 1'b0;
    expect_st(csl_pkg::CSL_LOCKOUT, 2'b10);
    $display("charge walk test done");
    @(posedge clk) {sup, en, pre, rch} <= 4'b1000;
    expect_st(csl_pkg::CSL_SLEEP, 2'b10);
    @(posedge clk) en <= 1'b1;
    expect_st(csl_pkg::CSL_QUAL, 2'b10);
    expect_st(csl_pkg::CSL_PRECON, 2'b01);
    ticks(7199, 0);
    expect_st(csl_pkg::CSL_PRECON, 2'b01);
    ticks(1, 3);
    expect_st(csl_pkg::CSL_TFAULT, 2'b10);
    for (i = 0; i < 4; i++)
    begin
      ticks(1, $urandom_range(8, 4));
      expect_st(csl_pkg::CSL_TFAULT, {i[0], 1'b0});
    end
    // divider as time base: exactly one toggle in any ten cycles
    @(posedge clk) usec <= 1'b0;
    @(posedge clk);
    @(negedge clk) p0 = pin;
    repeat (9) @(posedge clk);
    expect_st(csl_pkg::CSL_TFAULT, {~p0, 1'b0});
    @(posedge clk) bat <= 1'b0;
    expect_st(csl_pkg::CSL_NOBAT, 2'b10);
    @(posedge clk) en <= 1'b0;
    expect_st(csl_pkg::CSL_SLEEP, 2'b10);
    $display("timeout and flash test done");
    summarize();
  end
endmodule // testbench
